/* include/mdcsf_pkg.sv */
/*
  Shared constants for the motor drive configuration and speed feedback block:
  register offsets, field positions, reset values and voltage limits.
  Assumes a single 100 MHz device clock and a plain register port.
*/
`default_nettype none
package mdcsf_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SLEEP = 8'h04;
  localparam logic [7:0] OFF_SPEED = 8'h08;
  localparam logic [7:0] OFF_PULSE = 8'h0C;
  localparam logic [7:0] OFF_VOLT  = 8'h10;
  localparam logic [7:0] OFF_CAP   = 8'h14;
  localparam logic [7:0] OFF_STAT  = 8'h18;
  // Control register field positions; F_HIGH is the upper field of the threshold and pulse registers.
  localparam int F_MODE   = 0;
  localparam int F_DIR    = 2;
  localparam int F_BRK    = 4;
  localparam int F_STYLE  = 6;
  localparam int F_LOOP   = 7;
  localparam int F_PERS   = 9;
  localparam int F_MOD    = 10;
  localparam int F_DBC    = 11;
  localparam int F_CAP    = 12;
  localparam int F_SURGE  = 13;
  localparam int F_UVREC  = 14;
  localparam int F_OVREC  = 15;
  localparam int F_HIGH   = 16;
  // Override encodings.
  localparam logic [1:0] OVR_SET = 2'h1;
  localparam logic [1:0] OVR_CLR = 2'h2;
  // Power mode select encodings.
  localparam logic [1:0] PM_SLEEP   = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  // Speed pulse loop select encodings.
  localparam logic [1:0] LOOP_CLOSED = 2'h0;
  localparam logic [1:0] LOOP_OPEN   = 2'h1;
  // Supply thresholds in units of 0.1 V.
  localparam logic [8:0] LOW_MIN  = 9'h02D;
  localparam logic [8:0] LOW_MAX  = 9'h07D;
  localparam logic [8:0] HIGH_MIN = 9'h0C8;
  localparam logic [8:0] HIGH_MAX = 9'h15E;
  // Reset values.
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [15:0] RST_SLEEP = 16'hFFFF;
  localparam logic [4:0]  RST_DIV   = 5'h04;
  localparam logic [8:0]  RST_LOW   = 9'h05A;
  localparam logic [8:0]  RST_HIGH  = 9'h118;
  // Power state of the device.
  typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_STANDBY} mdcsf_pwr_e;
endpackage : mdcsf_pkg
`default_nettype wire

/* src/mdcsf_top.sv */
/*
  Configuration and supervision logic of a sensorless three-phase drive:
  sleep/standby, pin overrides, brake style, speed pulse output, modulation
  options, supply current cap, surge guard and supply voltage faults.
  Assumes estimator signals arrive on sys_clk_in; pins pass two flip-flops.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module mdcsf_top
  import mdcsf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic [15:0] speed_cmd_in,
  input  wire logic        dir_pin_in,
  input  wire logic        brake_pin_in,
  input  wire logic        drive_active_in,
  input  wire logic        closed_loop_in,
  input  wire logic        elec_pulse_in,
  input  wire logic [15:0] bemf_mv_in,
  input  wire logic [8:0]  supply_dv_in,
  input  wire logic [15:0] bus_current_in,
  output logic             motor_out_en_out,
  output logic             charge_pump_en_out,
  output logic             analog_reg_en_out,
  output logic             bus_en_out,
  output logic             rotate_cw_out,
  output logic             low_side_all_on_out,
  output logic             align_hold_out,
  output logic             speed_pulse_output_out,
  output logic             modulation_select_out,
  output logic             dead_band_correction_on_out,
  output logic             speed_limit_out,
  output logic             surge_guard_out,
  output logic             supply_under_fault_out,
  output logic             supply_over_fault_out
);

  logic [31:0] ctrl_q;
  logic [15:0] sleep_dly_q;
  logic [15:0] speed_thr_q;
  logic [4:0]  div_q;
  logic [15:0] emf_floor_q;
  logic [8:0]  low_thr_q;
  logic [8:0]  high_thr_q;
  logic [15:0] cap_q;
  logic [15:0] below_cnt_q;
  logic [4:0]  pulse_cnt_q;
  logic        pulse_q;
  logic        uv_q;
  logic        ov_q;
  logic [1:0]  dir_sync_q;
  logic [1:0]  brk_sync_q;
  logic        elec_prev_q;
  mdcsf_pwr_e  pwr_q;
  logic        bus_ok;
  logic        wr_ok;
  logic        below;
  logic        brake_on;
  logic        pulse_allowed;
  logic        loop_ok;
  logic [8:0]  wlow;
  logic [8:0]  whigh;
  logic        uv_cond;
  logic        ov_cond;
  logic        clr_uv;
  logic        clr_ov;

  // The serial bus is dead while asleep, so accesses then are dropped.
  assign bus_ok = (pwr_q != PS_SLEEP);
  assign wr_ok  = wr_in && bus_ok;
  assign clr_uv = wr_ok && (addr_in == OFF_STAT) && wdata_in[0];
  assign clr_ov = wr_ok && (addr_in == OFF_STAT) && wdata_in[1];

  // Threshold writes are clamped into the legal range.
  always_comb begin
    wlow  = wdata_in[8:0];
    whigh = wdata_in[F_HIGH +: 9];
    if (wlow < LOW_MIN) wlow = LOW_MIN;
    else if (wlow > LOW_MAX) wlow = LOW_MAX;
    if (whigh < HIGH_MIN) whigh = HIGH_MIN;
    else if (whigh > HIGH_MAX) whigh = HIGH_MAX;
  end

  // Configuration registers.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctrl_q      <= RST_CTRL;
      sleep_dly_q <= RST_SLEEP;
      speed_thr_q <= '0;
      div_q       <= RST_DIV;
      emf_floor_q <= '0;
      low_thr_q   <= RST_LOW;
      high_thr_q  <= RST_HIGH;
      cap_q       <= '1;
    end else if (wr_ok) begin
      if (addr_in == OFF_CTRL) ctrl_q <= wdata_in;
      else if (addr_in == OFF_SLEEP) sleep_dly_q <= wdata_in[15:0];
      else if (addr_in == OFF_SPEED) speed_thr_q <= wdata_in[15:0];
      else if (addr_in == OFF_PULSE) begin
        div_q       <= wdata_in[4:0];
        emf_floor_q <= wdata_in[F_HIGH +: 16];
      end else if (addr_in == OFF_VOLT) begin
        low_thr_q  <= wlow;
        high_thr_q <= whigh;
      end else if (addr_in == OFF_CAP) cap_q <= wdata_in[15:0];
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) rdata_out <= '0;
    else if (rd_in && bus_ok) begin
      if (addr_in == OFF_CTRL) rdata_out <= ctrl_q;
      else if (addr_in == OFF_SLEEP) rdata_out <= {16'h0000, sleep_dly_q};
      else if (addr_in == OFF_SPEED) rdata_out <= {16'h0000, speed_thr_q};
      else if (addr_in == OFF_PULSE) rdata_out <= {emf_floor_q, 11'h000, div_q};
      else if (addr_in == OFF_VOLT) rdata_out <= {7'h00, high_thr_q, 7'h00, low_thr_q};
      else if (addr_in == OFF_CAP) rdata_out <= {16'h0000, cap_q};
      else if (addr_in == OFF_STAT) rdata_out <= {27'h0, pulse_q, pwr_q, ov_q, uv_q};
      else rdata_out <= '0;
    end else rdata_out <= '0;
  end

  // Idle timer: counts cycles the speed command stays below threshold.
  assign below = (speed_cmd_in < speed_thr_q);
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) below_cnt_q <= '0;
    else if (!below) below_cnt_q <= '0;
    else if (below_cnt_q != 16'hFFFF) below_cnt_q <= below_cnt_q + 16'h0001;
  end

  // Power state; a rising speed command is the only way out of sleep.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) pwr_q <= PS_RUN;
    else begin
      case (pwr_q)
        PS_RUN: begin
          if (below && below_cnt_q >= sleep_dly_q) begin
            if (ctrl_q[F_MODE +: 2] == PM_SLEEP) pwr_q <= PS_SLEEP;
            else if (ctrl_q[F_MODE +: 2] == PM_STANDBY) pwr_q <= PS_STANDBY;
          end
        end
        default: begin
          if (!below) pwr_q <= PS_RUN;
        end
      endcase
    end
  end

  // Supply enables follow the power state.
  assign motor_out_en_out   = (pwr_q == PS_RUN);
  assign charge_pump_en_out = (pwr_q != PS_SLEEP);
  assign analog_reg_en_out  = (pwr_q != PS_SLEEP);
  assign bus_en_out         = bus_ok;

  // Direction and brake pins pass two flip-flops before use.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      dir_sync_q <= '0;
      brk_sync_q <= '0;
    end else begin
      dir_sync_q <= {dir_sync_q[0], dir_pin_in};
      brk_sync_q <= {brk_sync_q[0], brake_pin_in};
    end
  end

  // Overrides: 01 forces, 10 cancels, else the pin decides.
  always_comb begin
    if (ctrl_q[F_DIR +: 2] == OVR_SET) rotate_cw_out = 1'b1;
    else if (ctrl_q[F_DIR +: 2] == OVR_CLR) rotate_cw_out = 1'b0;
    else rotate_cw_out = dir_sync_q[1];
    if (ctrl_q[F_BRK +: 2] == OVR_SET) brake_on = 1'b1;
    else if (ctrl_q[F_BRK +: 2] == OVR_CLR) brake_on = 1'b0;
    else brake_on = brk_sync_q[1];
  end
  assign low_side_all_on_out = brake_on && !ctrl_q[F_STYLE] && motor_out_en_out;
  assign align_hold_out      = brake_on && ctrl_q[F_STYLE] && motor_out_en_out;

  // Modulation and protection option outputs.
  assign modulation_select_out       = ctrl_q[F_MOD];
  assign dead_band_correction_on_out = ctrl_q[F_DBC];
  assign speed_limit_out = ctrl_q[F_CAP] && (bus_current_in > cap_q);
  assign surge_guard_out = ctrl_q[F_SURGE];

  // Speed pulse gating by loop state, drive state and persistence.
  always_comb begin
    if (ctrl_q[F_LOOP +: 2] == LOOP_CLOSED) loop_ok = closed_loop_in;
    else if (ctrl_q[F_LOOP +: 2] == LOOP_OPEN) loop_ok = !closed_loop_in;
    else loop_ok = 1'b1;
    if (pwr_q != PS_RUN) pulse_allowed = 1'b0;
    else if (!ctrl_q[F_PERS]) pulse_allowed = drive_active_in && loop_ok;
    else pulse_allowed = (drive_active_in && loop_ok) || (bemf_mv_in >= emf_floor_q);
  end

  // Divider toggles the output every half pole count of electrical edges.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      elec_prev_q <= 1'b0;
      pulse_cnt_q <= '0;
      pulse_q     <= 1'b1;
    end else begin
      elec_prev_q <= elec_pulse_in;
      if (!pulse_allowed) begin
        pulse_cnt_q <= '0;
        pulse_q     <= 1'b1;
      end else if (elec_pulse_in && !elec_prev_q) begin
        if (pulse_cnt_q + 5'h01 >= (div_q >> 1)) begin
          pulse_cnt_q <= '0;
          pulse_q     <= !pulse_q;
        end else pulse_cnt_q <= pulse_cnt_q + 5'h01;
      end
    end
  end
  assign speed_pulse_output_out = pulse_q;

  // Supply faults: set wins over clear; auto mode clears when condition ends.
  assign uv_cond = (supply_dv_in < low_thr_q);
  assign ov_cond = (supply_dv_in > high_thr_q);
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      uv_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      if (uv_cond) uv_q <= 1'b1;
      else if (!ctrl_q[F_UVREC] || clr_uv) uv_q <= 1'b0;
      if (ov_cond) ov_q <= 1'b1;
      else if (!ctrl_q[F_OVREC] || clr_ov) ov_q <= 1'b0;
    end
  end
  assign supply_under_fault_out = uv_q;
  assign supply_over_fault_out  = ov_q;

  // Checks.
  sequence s_idle_done;
    (pwr_q == PS_RUN) && below && (below_cnt_q >= sleep_dly_q) && (ctrl_q[F_MODE +: 2] == PM_SLEEP);
  endsequence
  chk_sleep_entry: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_idle_done |=> (pwr_q == PS_SLEEP)) else $error("sleep not entered");
  chk_sleep_outputs: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q == PS_SLEEP) |-> !motor_out_en_out && !charge_pump_en_out && !bus_en_out)
    else $error("function alive in sleep");
  chk_sleep_bus: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q == PS_SLEEP) && rd_in |=> (rdata_out == 32'h0)) else $error("bus answered in sleep");
  chk_wake_up: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q != PS_RUN) && !below |=> (pwr_q == PS_RUN)) else $error("no wake");
  chk_dir_force: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ctrl_q[F_DIR +: 2] == OVR_SET) |-> rotate_cw_out) else $error("cw override lost");
  chk_brake_cancel: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ctrl_q[F_BRK +: 2] == OVR_CLR) |-> !low_side_all_on_out && !align_hold_out)
    else $error("brake despite cancel");
  chk_pulse_release: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q != PS_RUN) ##1 (pwr_q != PS_RUN) |-> speed_pulse_output_out) else $error("pulse not high");
  chk_uv_latch: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    uv_q && ctrl_q[F_UVREC] && !clr_uv |=> uv_q) else $error("latched fault dropped");
  chk_ov_auto: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ov_cond |=> ov_q ##0 (!ov_cond && !ctrl_q[F_OVREC]) [*1] |=> !ov_q)
    else $error("overvoltage handling wrong");
  chk_low_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (low_thr_q >= LOW_MIN) && (low_thr_q <= LOW_MAX)) else $error("low threshold out of range");
  chk_high_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (high_thr_q >= HIGH_MIN) && (high_thr_q <= HIGH_MAX))
    else $error("high threshold out of range");

  // A mode other than sleep must never reach the sleep state, however long the idle time.
  chk_mode_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q == PS_RUN) && (ctrl_q[F_MODE +: 2] != PM_SLEEP) |=> (pwr_q != PS_SLEEP))
    else $error("sleep entered in wrong mode");
  // Standby keeps the bus and supplies alive so software can still wake or inspect the block.
  chk_standby_outs: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (pwr_q == PS_STANDBY) |-> !motor_out_en_out && charge_pump_en_out && bus_en_out)
    else $error("standby outputs wrong");
  // Any sample at or above the threshold restarts the idle timer, so only a continuous dip counts.
  chk_idle_restart: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !below |=> (below_cnt_q == '0))
    else $error("idle timer not restarted");

  // Override and brake style checks: forced values must win over the synchronised pins; each brake output only in its style.
  chk_dir_cancel: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ctrl_q[F_DIR +: 2] == OVR_CLR) |-> !rotate_cw_out)
    else $error("ccw override lost");
  chk_brake_force: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ctrl_q[F_BRK +: 2] == OVR_SET) && motor_out_en_out |-> low_side_all_on_out || align_hold_out)
    else $error("forced brake missing");
  chk_low_side: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    low_side_all_on_out |-> !ctrl_q[F_STYLE] && !align_hold_out)
    else $error("low-side brake in wrong style");
  chk_align_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    align_hold_out |-> ctrl_q[F_STYLE] && !low_side_all_on_out)
    else $error("align in wrong style");

  // Without persistence an undriven motor must give a steady high output.
  chk_pulse_idle: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !ctrl_q[F_PERS] && !drive_active_in |=> speed_pulse_output_out)
    else $error("pulse while not driving");

  // Fault steps: the condition gone with auto recovery chosen, or a latched flag left alone.
  sequence s_uv_gone_auto;
    !uv_cond && !ctrl_q[F_UVREC];
  endsequence
  sequence s_ov_held;
    ov_q && ctrl_q[F_OVREC] && !clr_ov && !ov_cond;
  endsequence
  chk_uv_set: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    uv_cond |=> uv_q)
    else $error("undervoltage not flagged");
  chk_uv_auto: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_uv_gone_auto |=> !uv_q)
    else $error("undervoltage not cleared");
  chk_ov_latch: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_ov_held |=> ov_q)
    else $error("latched overvoltage dropped");
  chk_cap_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !ctrl_q[F_CAP] |-> !speed_limit_out)
    else $error("limit without cap");

endmodule : mdcsf_top
`default_nettype wire

/* tb/mdcsf_motor_model.sv */
/*
  Stand-in for the motor behind the power stage: electrical speed pulses and back-EMF.
  Assumes the bench clock; the rotor turns only while spin_in is high.
*/
`timescale 1ns/1ns
`default_nettype none
module mdcsf_motor_model #(
  parameter int HALF = 5
) (
  input  wire logic        sys_clk_in,
  input  wire logic        spin_in,
  output logic             elec_pulse_out,
  output logic      [15:0] bemf_mv_out
);
  int cnt = 0;
  initial elec_pulse_out = 1'b0;
  // A stopped rotor gives no pulses, so a stale edge can never be counted.
  always @(posedge sys_clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!spin_in) elec_pulse_out <= 1'b0;
    else if (cnt == HALF - 1) elec_pulse_out <= ~elec_pulse_out;
  end
  // Back-EMF falls to zero at once; real coasting decays, which is kinder.
  assign bemf_mv_out = spin_in ? 16'h0100 : 16'h0000;
endmodule : mdcsf_motor_model
`default_nettype wire

/* tb/mdcsf_top_test.sv */
/*
  Self-checking bench for mdcsf_top with the motor stand-in.
  Assumes one 100 MHz clock, the plain register port and the package constants.
*/
`timescale 1ns/1ns
`default_nettype none
module mdcsf_top_test
  import mdcsf_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, exp_q[$];
  logic [15:0] speed_cmd = 16'h0200, bemf, cur = 16'h0000, lfsr = 16'h8921;
  logic [8:0]  supply = 9'h0F0;
  logic        dir_pin = 1'b0, brk_pin = 1'b0, active = 1'b0, closed = 1'b0, spin = 1'b0, elec;
  logic        m_en, cp_en, reg_en, bus_en, cw, ls_on, align, pulse, mod_sel, dbc, limit, surge, uv, ov;
  logic        elec_d = 1'b0, pulse_d = 1'b1;
  int          fail_count = 0, compares = 0, rises = 0, toggles = 0;
  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;
  mdcsf_motor_model i_motor (.sys_clk_in(clk), .spin_in(spin), .elec_pulse_out(elec), .bemf_mv_out(bemf));
  mdcsf_top i_dut (.sys_clk_in(clk), .rstn_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .speed_cmd_in(speed_cmd), .dir_pin_in(dir_pin), .brake_pin_in(brk_pin),
    .drive_active_in(active), .closed_loop_in(closed), .elec_pulse_in(elec), .bemf_mv_in(bemf),
    .supply_dv_in(supply), .bus_current_in(cur), .motor_out_en_out(m_en), .charge_pump_en_out(cp_en),
    .analog_reg_en_out(reg_en), .bus_en_out(bus_en), .rotate_cw_out(cw), .low_side_all_on_out(ls_on),
    .align_hold_out(align), .speed_pulse_output_out(pulse), .modulation_select_out(mod_sel),
    .dead_band_correction_on_out(dbc), .speed_limit_out(limit), .surge_guard_out(surge),
    .supply_under_fault_out(uv), .supply_over_fault_out(ov));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Read data stand only in the cycle after the strobe, so the oldest note is taken exactly then.
  always @(posedge clk) begin
    if (rd_d) check("rdata", rdata, exp_q.pop_front());
    rd_d <= rd;
    elec_d <= elec;
    pulse_d <= pulse;
    if (elec && !elec_d) rises++;
    if (pulse !== pulse_d) toggles++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; exp_q.push_back(e); end
    @(posedge clk) rd <= 1'b0;
  endtask : rreg
  // Spins the motor for sixteen electrical edges and counts output toggles.
  task automatic run_pulse(input logic [4:0] div, input logic [31:0] ctl, input logic act, input logic cl,
                           input logic [15:0] floor, input int exp);
    wreg(OFF_PULSE, {floor, 11'h000, div});
    wreg(OFF_CTRL, ctl);
    // Counters clear while the rotor still stands, so no edge can fall between clear and count.
    tick(1);
    rises = 0;
    toggles = 0;
    @(posedge clk) begin active <= act; closed <= cl; spin <= 1'b1; end
    for (int i = 0; i < 400 && rises < 16; i++) tick(1);
    @(posedge clk) spin <= 1'b0;
    tick(12);
    check("pulse toggles", toggles, exp);
    @(posedge clk) active <= 1'b0;
    tick(3);
    check("pulse idle", 32'(pulse), 32'h1);
  endtask : run_pulse
  // Hang guard, reckoned well above the few thousand cycles the tests need.
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rreg(OFF_CTRL, RST_CTRL);
    rreg(OFF_SLEEP, 32'(RST_SLEEP));
    rreg(OFF_VOLT, {7'h0, RST_HIGH, 7'h0, RST_LOW});
    rreg(OFF_CAP, 32'h0000_FFFF);
    rreg(OFF_STAT, 32'h0000_0010);
    rreg(8'h1C, 32'h0);
    $display("test reset values done");
    wreg(OFF_VOLT, 32'h01FF_0000);
    rreg(OFF_VOLT, {7'h0, HIGH_MAX, 7'h0, LOW_MIN});
    wreg(OFF_VOLT, {7'h0, HIGH_MIN, 7'h0, LOW_MAX});
    rreg(OFF_VOLT, {7'h0, HIGH_MIN, 7'h0, LOW_MAX});
    wreg(OFF_VOLT, {7'h0, RST_HIGH, 7'h0, RST_LOW});
    $display("test threshold range done");
    // Pass 0 recovers on its own, pass 1 latches until software clears.
    for (int i = 0; i < 2; i++) begin
      wreg(OFF_CTRL, (32'(i) << F_UVREC) | (32'(i) << F_OVREC));
      @(posedge clk) supply <= 9'h050;
      tick(4);
      check("uv set", 32'(uv), 32'h1);
      @(posedge clk) supply <= 9'h12C;
      tick(4);
      check("uv after", 32'(uv), 32'(i));
      check("ov set", 32'(ov), 32'h1);
      @(posedge clk) supply <= 9'h0F0;
      tick(4);
      check("ov after", 32'(ov), 32'(i));
      wreg(OFF_STAT, 32'h0000_0003);
      tick(2);
      check("faults clear", 32'({uv, ov}), 32'h0);
    end
    $display("test supply faults done");
    for (int i = 0; i < 3; i++) begin
      wreg(OFF_CTRL, 32'(i) << F_DIR);
      @(posedge clk) dir_pin <= (i != 1);
      tick(4);
      check("rotate cw", 32'(cw), 32'(i != 2));
    end
    for (int j = 0; j < 4; j++) begin
      wreg(OFF_CTRL, (j < 2 ? 32'h10 : 32'h20) | (32'(j % 2) << F_STYLE));
      @(posedge clk) brk_pin <= (j >= 2);
      tick(4);
      check("brake", 32'({ls_on, align}), j < 2 ? 32'(2 - j) : 32'h0);
    end
    $display("test overrides done");
    for (int i = 0; i < 2; i++) begin
      wreg(OFF_CTRL, i ? 32'h0000_2C00 : 32'h0);
      tick(2);
      check("ctrl outs", 32'({mod_sel, dbc, surge}), i ? 32'h7 : 32'h0);
    end
    wreg(OFF_CAP, 32'h0000_8000);
    wreg(OFF_CTRL, 32'h0000_1000);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) cur <= lfsr;
      lfsr = lfsr_next(lfsr);
      tick(1);
      check("speed limit", 32'(limit), 32'(cur > 16'h8000));
    end
    wreg(OFF_CTRL, 32'h0);
    tick(2);
    check("limit off", 32'(limit), 32'(1'b0));
    $display("test drive options done");
    run_pulse(5'h01, 32'h0, 1'b1, 1'b1, 16'h0080, 16);
    run_pulse(5'h02, 32'h0, 1'b1, 1'b1, 16'h0080, 16);
    run_pulse(5'h04, 32'h0, 1'b1, 1'b1, 16'h0080, 8);
    run_pulse(5'h08, 32'h0, 1'b1, 1'b1, 16'h0080, 4);
    run_pulse(5'h04, 32'h0, 1'b1, 1'b0, 16'h0080, 0);
    run_pulse(5'h04, 32'h80, 1'b1, 1'b0, 16'h0080, 8);
    run_pulse(5'h04, 32'h80, 1'b1, 1'b1, 16'h0080, 0);
    run_pulse(5'h04, 32'h100, 1'b1, 1'b1, 16'h0080, 8);
    run_pulse(5'h04, 32'h0, 1'b0, 1'b1, 16'h0080, 0);
    run_pulse(5'h04, 32'h200, 1'b0, 1'b1, 16'h0080, 8);
    run_pulse(5'h04, 32'h200, 1'b0, 1'b1, 16'h0200, 0);
    $display("test speed pulse done");
    wreg(OFF_SPEED, 32'h0000_0100);
    wreg(OFF_SLEEP, 32'h0000_0014);
    // Mode 0, then standby, then sleep; the speed command dips below threshold in each.
    for (int m = 0; m < 3; m++) begin
      wreg(OFF_CTRL, m == 0 ? 32'h0 : 32'(m == 1 ? PM_STANDBY : PM_SLEEP));
      @(posedge clk) speed_cmd <= 16'h0050;
      tick(15);
      @(posedge clk) speed_cmd <= 16'h0200;
      @(posedge clk) speed_cmd <= 16'h0050;
      tick(15);
      check("still awake", 32'(m_en), 32'h1);
      tick(12);
      check("power outs", 32'({m_en, cp_en, reg_en, bus_en}), m == 0 ? 32'hF : m == 1 ? 32'h7 : 32'h0);
      check("pulse high", 32'(pulse), 32'h1);
      if (m == 1) rreg(OFF_STAT, 32'h0000_0018);
      if (m == 2) wreg(OFF_SPEED, 32'h0);
      if (m == 2) rreg(OFF_CTRL, 32'h0);
      @(posedge clk) speed_cmd <= 16'h0200;
      tick(3);
      check("awake again", 32'({m_en, cp_en, reg_en, bus_en}), 32'hF);
      rreg(OFF_SPEED, 32'h0000_0100);
    end
    $display("test power modes done");
    tick(4);
    tally_and_finish();
  end
endmodule : mdcsf_top_test
`default_nettype wire
